/* src/vfds_pkg.sv */
package vfds_pkg;

  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam logic [15:0] VFDS_ADDR_MODE_A = 16'hFFA0;
  localparam logic [15:0] VFDS_ADDR_MODE_B = 16'hFFA1;
  localparam logic [15:0] VFDS_ADDR_MASK = 16'hFFA2;
  localparam logic [7:0] VFDS_RST_MODE_A = 8'h00;
  localparam logic [7:0] VFDS_RST_MODE_B = 8'h00;
  localparam logic [7:0] VFDS_RST_MASK = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int VFDS_KSF_BIT = 7;
  localparam int VFDS_MODE2_BIT = 5;
  localparam int VFDS_NOISE_BIT = 6;

  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int VFDS_N_LINES = 53;
  localparam int VFDS_N_SHARED = 40;
  localparam int VFDS_N_FIXED = 13;
  localparam int VFDS_REC_BYTES = 7;
  localparam logic [7:0] VFDS_REC_STRIDE = 8'h08;
  localparam logic [5:0] VFDS_SEG_MIN = 6'h09;
  localparam logic [10:0] VFDS_SLOT_SHORT_CYC = 11'h3FF;
  localparam logic [10:0] VFDS_SLOT_LONG_CYC = 11'h7FF;
  localparam logic [10:0] VFDS_FETCH_START_CNT = 11'h000;
  localparam logic [10:0] VFDS_LOAD_CNT = 11'h009;
  localparam logic [7:0] VFDS_AREA_BYTES = 8'h80;

  // Decoded configuration carried between files
  typedef struct packed {
    logic mode2;
    logic [4:0] seg_code;
    logic slot_long;
    logic [2:0] cut_code;
    logic [3:0] dig_code;
    logic [7:0] mask_cnt;
  } vfds_cfg_t;

endpackage : vfds_pkg

/* src/vfds_slot_timer.sv */
`timescale 1ns/1ps
module vfds_slot_timer
  import vfds_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic run,
  input wire logic slot_long,
  input wire logic [4:0] ndig,
  output logic [10:0] cnt,
  output logic [4:0] slot_idx,
  output logic slot_start,
  output logic key_slot
);

  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [4:0] idx_q;
  logic [4:0] idx_d;
  logic [10:0] last_w;
  logic wrap_w;

  // Slot length picks 1024 or 2048 clocks
  assign last_w = slot_long ? VFDS_SLOT_LONG_CYC : VFDS_SLOT_SHORT_CYC;
  assign wrap_w = (cnt_q == last_w);
  // Key slot follows the last digit and lasts one slot
  assign cnt_d = (!run || wrap_w) ? 11'h000 : cnt_q + 11'h001;
  assign idx_d = !run ? 5'h00 :
                 !wrap_w ? idx_q :
                 (idx_q >= ndig) ? 5'h00 : idx_q + 5'h01;

  // Counters held at zero while stopped
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= 11'h000;
      idx_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
      idx_q <= idx_d;
    end
  end

  assign cnt = cnt_q;
  assign slot_idx = idx_q;
  assign slot_start = run && (cnt_q == VFDS_FETCH_START_CNT);
  assign key_slot = run && (idx_q == ndig);

endmodule : vfds_slot_timer

/* src/vfds_fetch.sv */
`timescale 1ns/1ps
module vfds_fetch
  import vfds_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic [7:0] base,
  output logic mem_rd_en,
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic [55:0] word
);

  logic busy_q;
  logic [2:0] byte_q;
  logic cap_q;
  logic [2:0] cap_idx_q;
  logic [55:0] word_q;
  logic last_w;

  assign last_w = (byte_q == 3'(VFDS_REC_BYTES - 1));
  assign mem_rd_en = busy_q;
  assign mem_addr = base + {5'h00, byte_q};

  // Read one byte per clock, data returns a cycle later
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
      byte_q <= 3'h0;
      cap_q <= 1'b0;
      cap_idx_q <= 3'h0;
    end else begin
      cap_q <= busy_q;
      cap_idx_q <= byte_q;
      if (start) begin
        busy_q <= 1'b1;
        byte_q <= 3'h0;
      end else if (busy_q) begin
        busy_q <= !last_w;
        byte_q <= last_w ? 3'h0 : byte_q + 3'h1;
      end
    end
  end

  // Assemble the record, low address in low bits
  always_ff @(posedge mclk) begin
    if (srst) begin
      word_q <= '0;
    end else if (cap_q) begin
      word_q[cap_idx_q*8 +: 8] <= mem_rdata;
    end
  end

  assign word = word_q;

endmodule : vfds_fetch

/* src/vfds_scanner.sv */
// Contract
// - Fetch display data by itself, drive outputs
// - Support 9-40 segments and 2-16 digits
// - Pattern mode takes digit levels from memory
// - Eight brightness levels from second mode register
// - Pulse an interrupt at key slot start
// - Flag reads set only during key slot
// - Key slot drives segments from port latches
// - Slot lasts 1024 or 2048 clocks
// - Frame is slot times digits plus one
// - Key slot as long as digit slot
// - Digit pulse width chosen from eight values
// - Segment pulses cut by three-bit field
// - Digit count zero stops display, frees pins
// - 53 lines, 40 shared, 13 display-only
// - Unused lines stay ordinary ports while running
// - No display without main oscillator
// - Pattern mode protects masked data bits
// - Byte writes to first register, flag bit-readable
// - Reset clears all three mode registers
// - Segment code zero is nine, up to forty
// - Mode bit selects character or pattern mode
`timescale 1ns/1ps
module vfds_scanner
  import vfds_pkg::*;
#(
  parameter logic [7:0] DISP_BASE = 8'h00
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic main_osc_sel,
  output logic mem_rd_en,
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic [39:0] key_port_data,
  input wire logic [7:0] ram_wr_addr,
  output logic [7:0] ram_wr_bitmask,
  output logic [52:0] disp_out,
  output logic [39:0] port_release,
  output logic key_scan_irq,
  output logic key_scan_flag
);

  // ****************************************
  // Register file
  // ****************************************
  logic [6:0] mode_a_q;
  logic [7:0] mode_b_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic ksf_q;
  logic irq_q;
  logic sel_a_w;
  logic sel_b_w;
  logic sel_m_w;
  logic [7:0] rd_mux_w;
  vfds_cfg_t cfg_w;

  // Address decode for the three mode registers
  assign sel_a_w = (reg_addr == VFDS_ADDR_MODE_A);
  assign sel_b_w = (reg_addr == VFDS_ADDR_MODE_B);
  assign sel_m_w = (reg_addr == VFDS_ADDR_MASK);

  // Flag bit is read-only, a write to it is dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_a_q <= VFDS_RST_MODE_A[6:0];
      mode_b_q <= VFDS_RST_MODE_B;
      mask_q <= VFDS_RST_MASK;
    end else if (reg_wr) begin
      if (sel_a_w) begin
        mode_a_q <= reg_wdata[6:0];
      end
      if (sel_b_w) begin
        mode_b_q <= reg_wdata;
      end
      if (sel_m_w) begin
        mask_q <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  assign rd_mux_w = sel_a_w ? {ksf_q, mode_a_q} :
                    sel_b_w ? mode_b_q :
                    sel_m_w ? mask_q : 8'h00;

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux_w;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Configuration decode
  // ****************************************
  logic run_w;
  logic [4:0] ndig_w;
  logic [5:0] nseg_w;
  logic [6:0] nused_w;

  assign cfg_w.mode2 = mode_a_q[VFDS_MODE2_BIT];
  assign cfg_w.seg_code = mode_a_q[4:0];
  assign cfg_w.slot_long = mode_b_q[0];
  assign cfg_w.cut_code = mode_b_q[3:1];
  assign cfg_w.dig_code = mode_b_q[7:4];
  assign cfg_w.mask_cnt = mask_q;

  // Zero digit code or sub clock means stopped
  assign run_w = (cfg_w.dig_code != 4'h0) && main_osc_sel;
  // Digit code n gives n+1 digits, 2 to 16
  assign ndig_w = {1'b0, cfg_w.dig_code} + 5'h01;
  // Segment code zero gives nine lines, all ones forty
  assign nseg_w = {1'b0, cfg_w.seg_code} + VFDS_SEG_MIN;
  // Lines in use; digits keep priority past 53
  assign nused_w = {2'b00, ndig_w} + {1'b0, nseg_w};

  // ****************************************
  // Slot timing and data fetch
  // ****************************************
  logic [10:0] cnt_w;
  logic [4:0] idx_w;
  logic start_w;
  logic key_w;
  logic [55:0] fetch_w;
  logic [7:0] rec_base_w;

  vfds_slot_timer u_timer (
    .mclk(mclk),
    .srst(srst),
    .run(run_w),
    .slot_long(cfg_w.slot_long),
    .ndig(ndig_w),
    .cnt(cnt_w),
    .slot_idx(idx_w),
    .slot_start(start_w),
    .key_slot(key_w)
  );

  // One seven-byte record per digit slot, records eight bytes apart
  assign rec_base_w = DISP_BASE + (idx_w[3:0] * VFDS_REC_STRIDE);

  // No fetch in the key slot, port latches are used instead
  vfds_fetch u_fetch (
    .mclk(mclk),
    .srst(srst),
    .start(start_w && !key_w),
    .base(rec_base_w),
    .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr),
    .mem_rdata(mem_rdata),
    .word(fetch_w)
  );

  // ****************************************
  // Key-scan flag and interrupt
  // ****************************************
  logic key_prev_q;

  // Flag follows the slot; irq pulses on its first clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      ksf_q <= 1'b0;
      key_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ksf_q <= key_w;
      key_prev_q <= key_w;
      irq_q <= key_w && !key_prev_q;
    end
  end

  assign key_scan_flag = ksf_q;
  assign key_scan_irq = irq_q;

  // ****************************************
  // Output shaping
  // ****************************************
  logic [55:0] word_q;
  logic [11:0] cut_cyc_w;
  logic visible_w;
  logic [55:0] seg_vec_w;
  logic [55:0] key_vec_w;
  logic [52:0] out_d;
  logic [52:0] out_q;

  // Load the fresh record while the cut still blanks output
  always_ff @(posedge mclk) begin
    if (srst) begin
      word_q <= '0;
    end else if (run_w && (cnt_w == VFDS_LOAD_CNT)) begin
      word_q <= fetch_w;
    end
  end

  // Cut width is (code+1)*64 clocks in both slot lengths, (code+1)/16 of a short slot
  assign cut_cyc_w = cfg_w.slot_long ?
                     {2'b00, {1'b0, cfg_w.cut_code} + 4'h1, 6'h00} :
                     {3'b000, {1'b0, cfg_w.cut_code} + 4'h1, 5'h00} <<
                     1;
  // Larger cut, shorter pulse: eight brightness steps
  assign visible_w = {1'b0, cnt_w} >= cut_cyc_w;

  // Segment bits start on the line after the last digit
  assign seg_vec_w = fetch_seg(word_q, ndig_w);
  assign key_vec_w = fetch_seg({16'h0000, key_port_data}, ndig_w);

  // Align a record so bit 0 lands on the first segment line
  function automatic logic [55:0] fetch_seg(
    input logic [55:0] v,
    input logic [4:0] nd
  );
    fetch_seg = v << nd;
  endfunction : fetch_seg

  // Line class: digit, segment, or unused
  function automatic logic [1:0] line_class(
    input int i,
    input logic [4:0] nd,
    input logic [6:0] nu
  );
    line_class = (i < int'(nd)) ? 2'h1 :
                 (i < int'(nu)) ? 2'h2 : 2'h0;
  endfunction : line_class

  genvar gl;
  generate
    for (gl = 0; gl < VFDS_N_LINES; gl++) begin : g_line
      logic [1:0] cls_w;
      logic dig_w;
      logic seg_w;
      assign cls_w = line_class(gl, ndig_w, nused_w);
      // Character mode walks digits; pattern mode reads memory
      assign dig_w = cfg_w.mode2 ? word_q[gl] :
                     (idx_w == 5'(gl));
      assign seg_w = cfg_w.mode2 ? word_q[gl] : seg_vec_w[gl];
      assign out_d[gl] = !run_w || !visible_w ? 1'b0 :
                         key_w ? (cls_w == 2'h2) && key_vec_w[gl] :
                         (cls_w == 2'h1) ? dig_w :
                         (cls_w == 2'h2) ? seg_w : 1'b0;
      if (gl >= VFDS_N_FIXED) begin : g_shared
        // Shared line returns to port when unused or stopped
        assign port_release[gl - VFDS_N_FIXED] =
          !run_w || (cls_w == 2'h0);
      end
    end
  endgenerate

  // Outputs from flops to keep pins glitch free
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign disp_out = out_q;

  // ****************************************
  // Rewrite protection in pattern mode
  // ****************************************
  logic [7:0] area_off_w;
  logic in_area_w;
  logic protect_on_w;

  // Offset inside the display area counts from its lowest byte
  assign area_off_w = ram_wr_addr - DISP_BASE;
  assign in_area_w = area_off_w < VFDS_AREA_BYTES;
  assign protect_on_w = run_w && cfg_w.mode2 && in_area_w;

  // Count relies on software staying below outputs in use
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_mask
      logic [7:0] bitpos_w;
      assign bitpos_w = {2'b00, area_off_w[2:0], 3'(gb)};
      assign ram_wr_bitmask[gb] =
        !(protect_on_w && (bitpos_w < cfg_w.mask_cnt));
    end
  endgenerate

endmodule : vfds_scanner

/* test/vfds_scanner_monitor.sv */
`timescale 1ns/1ps
module vfds_scanner_monitor
  import vfds_pkg::*;
#(
  parameter logic [7:0] DISP_BASE = 8'h00
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic main_osc_sel,
  input wire logic mem_rd_en,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] ram_wr_addr,
  input wire logic [7:0] ram_wr_bitmask,
  input wire logic [52:0] disp_out,
  input wire logic key_scan_irq,
  input wire logic key_scan_flag
);
  // ****************************************
  // Helpers
  // ****************************************
  // Nine-bit offset: addresses below the base wrap out of range
  logic [8:0] wr_off;
  logic mapped;
  assign wr_off = {1'b0, ram_wr_addr} - {1'b0, DISP_BASE};
  assign mapped = reg_addr inside
    {VFDS_ADDR_MODE_A, VFDS_ADDR_MODE_B, VFDS_ADDR_MASK};

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // ****************************************
  // Properties
  // ****************************************
  // Key slot events
  AST_IRQ_AT_RISE: assert property (
    key_scan_irq |-> key_scan_flag && !$past(key_scan_flag))
    else $error("irq away from flag rise");
  AST_IRQ_PULSE: assert property (
    key_scan_irq |=> !key_scan_irq) else $error("irq too long");
  AST_KEY_DIGITS: assert property (
    key_scan_flag && $past(key_scan_flag) |-> disp_out[1:0] == 2'b00)
    else $error("digit lit in key slot");
  // Margin of three cycles covers the output flops
  AST_OSC_DARK: assert property (
    !main_osc_sel [*3] |-> disp_out == '0 && !key_scan_flag)
    else $error("display runs without main clock");
  AST_OSC_NO_IRQ: assert property (
    !main_osc_sel [*3] |-> !key_scan_irq) else $error("irq while stopped");
  AST_UNMAPPED: assert property (
    reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BURST: assert property (
    $rose(mem_rd_en) |-> mem_rd_en [*7] ##1 !mem_rd_en)
    else $error("fetch burst length wrong");
  AST_BURST_ADDR: assert property (
    $rose(mem_rd_en) |-> mem_addr[2:0] == 3'h0 ##6 mem_addr[2:0] == 3'h6)
    else $error("fetch addresses wrong");
  AST_MASK_OUT: assert property (
    wr_off[8:7] != 2'b00 |-> ram_wr_bitmask == 8'hFF)
    else $error("mask outside display area");

  // Main scenarios reached
  COV_IRQ: cover property (key_scan_irq);
  COV_MASK: cover property (ram_wr_bitmask == 8'hF8);
  COV_FETCH: cover property ($fell(mem_rd_en));
endmodule : vfds_scanner_monitor

bind vfds_scanner vfds_scanner_monitor #(.DISP_BASE(DISP_BASE)) mon (
  .mclk(mclk), .srst(srst), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .main_osc_sel(main_osc_sel),
  .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .ram_wr_addr(ram_wr_addr),
  .ram_wr_bitmask(ram_wr_bitmask), .disp_out(disp_out),
  .key_scan_irq(key_scan_irq), .key_scan_flag(key_scan_flag));

/* test/vfds_ram_model.sv */
`timescale 1ns/1ps
module vfds_ram_model
  import vfds_pkg::*;
(
  input wire logic mclk,
  input wire logic mem_rd_en,
  input wire logic [7:0] mem_addr,
  output logic [7:0] mem_rdata
);
  // ****************************************
  // Display memory
  // ****************************************
  // Answers one cycle late; idle cycles toggle so stale data never
  // passes for a fresh read
  always_ff @(posedge mclk) begin
    if (mem_rd_en) begin
      mem_rdata <= mem_addr ^ 8'hA5;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : vfds_ram_model

/* test/test_vfds_scanner.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h %h", $time, a, b); end end
module test_vfds_scanner
  import vfds_pkg::*;
;
  logic mclk, srst, reg_wr, reg_rd, main_osc_sel, mem_rd_en;
  logic key_scan_irq, key_scan_flag;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mem_addr, mem_rdata;
  logic [7:0] ram_wr_addr, ram_wr_bitmask;
  logic [39:0] key_port_data, port_release;
  logic [52:0] disp_out;
  int failures, check_count, n;

  vfds_scanner #(.DISP_BASE(8'h00)) dut (.mclk, .srst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .main_osc_sel, .mem_rd_en,
    .mem_addr, .mem_rdata, .key_port_data, .ram_wr_addr, .ram_wr_bitmask,
    .disp_out, .port_release, .key_scan_irq, .key_scan_flag);
  vfds_ram_model ram (.mclk, .mem_rd_en, .mem_addr, .mem_rdata);

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data holds after the strobe, so one extra edge avoids the race
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    `CHK(reg_rdata, exp)
  endtask : rd

  // Bounded wait; n ends as the cycles waited
  task wait_irq;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (key_scan_irq !== 1'b1 && n < 8000);
    if (key_scan_irq !== 1'b1) begin
      failures++;
      print_verdict;
    end
  endtask : wait_irq

  task frame(input logic [7:0] mode_b, input int exp);
    wr(VFDS_ADDR_MODE_B, mode_b);
    wait_irq;
    wait_irq;
    `CHK(n, exp)
  endtask : frame

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    main_osc_sel = 1'b1;
    // Key ports zero until the display runs
    key_port_data = 40'h00_0000_0000;
    ram_wr_addr = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    // Three registers then one unmapped place
    for (int i = 0; i < 4; i++) rd(VFDS_ADDR_MODE_A + 16'(i), 8'h00);
    `CHK(port_release, 40'hFF_FFFF_FFFF)
    wr(VFDS_ADDR_MODE_A, 8'h9F);
    rd(VFDS_ADDR_MODE_A, 8'h1F);
    wr(VFDS_ADDR_MODE_B, 8'h10);
    @(posedge mclk);
    `CHK(port_release, 40'hFF_E000_0000)
    key_port_data <= 40'h00_0000_0136;
    wr(VFDS_ADDR_MODE_A, 8'h00);
    @(posedge mclk);
    `CHK(port_release, 40'hFF_FFFF_FFFF)
    frame(8'h10, 3072);
    n = 0;
    while (key_scan_flag === 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n, 1024)
    // Mid-slot samples: digit 0, digit 1, then key slot
    repeat (500) @(posedge mclk);
    `CHK(disp_out[10:0], {9'h0A5, 2'b01})
    repeat (1024) @(posedge mclk);
    `CHK(disp_out[10:0], {9'h0AD, 2'b10})
    repeat (1024) @(posedge mclk);
    `CHK(disp_out[10:0], {9'h136, 2'b00})
    rd(VFDS_ADDR_MODE_A, 8'h80);
    // Widest cut blanks the first 512 cycles
    wr(VFDS_ADDR_MODE_B, 8'h1E);
    wait_irq;
    repeat (300) @(posedge mclk);
    `CHK(disp_out, 53'h0)
    repeat (400) @(posedge mclk);
    `CHK(disp_out[10:0], {9'h136, 2'b00})
    frame(8'h20, 4096);
    frame(8'h11, 6144);
    wr(VFDS_ADDR_MODE_B, 8'h10);
    // Fourteen outputs in total, so eleven mask bits stay legal
    wr(VFDS_ADDR_MODE_A, 8'h23);
    wait_irq;
    repeat (1524) @(posedge mclk);
    `CHK(disp_out[10:0], 11'h4A5)
    // Eleven protected bits from the area start
    wr(VFDS_ADDR_MASK, 8'h0B);
    ram_wr_addr <= 8'h00;
    @(posedge mclk);
    `CHK(ram_wr_bitmask, 8'h00)
    ram_wr_addr <= 8'h01;
    @(posedge mclk);
    `CHK(ram_wr_bitmask, 8'hF8)
    ram_wr_addr <= 8'h02;
    @(posedge mclk);
    `CHK(ram_wr_bitmask, 8'hFF)
    // Past the display area nothing is protected
    ram_wr_addr <= 8'h80;
    @(posedge mclk);
    `CHK(ram_wr_bitmask, 8'hFF)
    wr(VFDS_ADDR_MODE_A, 8'h00);
    ram_wr_addr <= 8'h00;
    @(posedge mclk);
    `CHK(ram_wr_bitmask, 8'hFF)
    rd(VFDS_ADDR_MASK, 8'h0B);
    // Stops: digit code zero, then main clock gone
    key_port_data <= 40'h00_0000_0000;
    wr(VFDS_ADDR_MODE_B, 8'h00);
    repeat (2) @(posedge mclk);
    `CHK(port_release, 40'hFF_FFFF_FFFF)
    `CHK(disp_out, 53'h0)
    wr(VFDS_ADDR_MODE_B, 8'h10);
    wait_irq;
    // Display stopped before the main clock goes away
    wr(VFDS_ADDR_MODE_B, 8'h00);
    main_osc_sel <= 1'b0;
    wr(VFDS_ADDR_MODE_B, 8'h10);
    repeat (4) @(posedge mclk);
    `CHK(disp_out, 53'h0)
    `CHK(key_scan_flag, 1'b0)
    main_osc_sel <= 1'b1;
    wait_irq;
    // Reset in mid-run clears every register
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(VFDS_ADDR_MODE_A + 16'(i), 8'h00);
    print_verdict;
  end
endmodule : test_vfds_scanner
